// >>> rtl/sdc_cfg.svh
// Purpose: constants of the synchronous dram command and address port
// Assumes: one clock, synchronous inputs
// Notes: mode register field encodings follow the usual sdram layout
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

`define SDC_ROW_W 11
`define SDC_COL_W 8
`define SDC_OP_W 12
`define SDC_DW 16
`define SDC_MEM_AW 20

`define SDC_CMD_MRS 3'h0
`define SDC_CMD_REF 3'h1
`define SDC_CMD_PRE 3'h2
`define SDC_CMD_ACT 3'h3
`define SDC_CMD_WR 3'h4
`define SDC_CMD_RD 3'h5
`define SDC_CMD_BST 3'h6

`define SDC_PSCOPE_BIT 10
`define SDC_MR_BL_LSB 0
`define SDC_MR_BL_MSB 2
`define SDC_MR_BT_BIT 3
`define SDC_MR_CL_LSB 4
`define SDC_MR_CL_MSB 6
`define SDC_MR_WBS_BIT 9
`define SDC_MR_RESET 12'h020

`define SDC_BL_1 3'h0
`define SDC_BL_2 3'h1
`define SDC_BL_4 3'h2
`define SDC_BL_8 3'h3
`define SDC_BL_FULL 3'h7
`define SDC_CL_3 3'h3

`define SDC_MASK_1 8'h00
`define SDC_MASK_2 8'h01
`define SDC_MASK_4 8'h03
`define SDC_MASK_8 8'h07
`define SDC_MASK_FULL 8'hff

`define SDC_OFS_MODE 32'h0000_0000
`define SDC_OFS_STATUS 32'h0000_0004
`define SDC_OFS_ROWS 32'h0000_0008
`define SDC_RESP_OKAY 2'h0
`define SDC_RESP_SLVERR 2'h2

`endif

// >>> rtl/sdc_pkg.sv
// Purpose: types of the synchronous dram command and address port
// Assumes: constants come from sdc_cfg.svh
// Notes: struct widths are fixed by the pin count of the part
package sdc_pkg;
    typedef enum logic [2:0] {
        st_idle = 3'h1,
        st_read = 3'h2,
        st_write = 3'h4
    } sdc_state_e;

    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic bank_select_input;
        logic [10:0] addr;
        logic high_byte_mask;
        logic low_byte_mask;
    } sdc_pins_s;

    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } sdc_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sdc_axi_rsp_s;
endpackage : sdc_pkg

// >>> rtl/sdc_mem.sv
// Purpose: storage array of both banks
// Assumes: one access per cycle, read or write
// Notes: read data registered, held while no read is requested
`timescale 1ns/1ps
module sdc_mem #(
    parameter int AW = 20,
    parameter int DW = 16
)
(
    input wire logic clk_sys,
    input wire logic we,
    input wire logic re,
    input wire logic [DW/8-1:0] be,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata_r
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_sys)
    begin
        if (we)
        begin
            for (int i = 0; i < DW/8; i++)
                if (be[i])
                    mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
        end
        if (re)
            rdata_r <= mem[addr];
    end
endmodule : sdc_mem

// >>> rtl/sdc_top.sv
// Purpose: device side of a two-bank 16-bit synchronous dram command port
// Assumes: pins synchronous to clk_sys; registers reached over axi4-lite
// Notes: cke low freezes the whole pin-facing state for that edge, except the mode register, which an axi4-lite write still sets
`timescale 1ns/1ps
`include "sdc_cfg.svh"

module sdc_top
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire sdc_pkg::sdc_pins_s pins,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic [1:0] dq_oe,
    input wire sdc_pkg::sdc_axi_req_s axi_req,
    output sdc_pkg::sdc_axi_rsp_s axi_rsp
);
    import sdc_pkg::*;

    localparam int COL_W = `SDC_COL_W;
    localparam int ROW_W = `SDC_ROW_W;

    function automatic logic [COL_W-1:0] bl_mask(input logic [2:0] code);
        logic [COL_W-1:0] m;
        case (code)
            `SDC_BL_2: m = `SDC_MASK_2;
            `SDC_BL_4: m = `SDC_MASK_4;
            `SDC_BL_8: m = `SDC_MASK_8;
            `SDC_BL_FULL: m = `SDC_MASK_FULL;
            default: m = `SDC_MASK_1;
        endcase
        return m;
    endfunction : bl_mask

    // wraps inside the burst-aligned block, so the upper column bits never move
    function automatic logic [COL_W-1:0] burst_col(
        input logic [COL_W-1:0] base,
        input logic [COL_W-1:0] idx,
        input logic [COL_W-1:0] mask,
        input logic ileave
    );
        logic [COL_W-1:0] off;
        off = ileave ? (base ^ idx) : (base + idx);
        return (base & ~mask) | (off & mask);
    endfunction : burst_col

    sdc_state_e state_r, state_nxt;
    logic bank_r, bank_nxt;
    logic [COL_W-1:0] base_r, base_nxt;
    logic [COL_W-1:0] idx_r, idx_nxt;
    logic [COL_W-1:0] mask_r, mask_nxt;
    logic [COL_W:0] left_r, left_nxt;
    logic ap_r, ap_nxt;
    logic il_r, il_nxt;
    logic full_r, full_nxt;
    logic [1:0] active_r, active_nxt;
    logic [1:0][ROW_W-1:0] row_r, row_nxt;
    logic [`SDC_OP_W-1:0] mode_r, mode_nxt;
    logic [15:0] refcnt_r, refcnt_nxt;
    logic rv0_r, rv0_nxt;
    logic rv1_r, rv1_nxt;
    logic [1:0] m0_r, m0_nxt;
    logic [1:0] m1_r, m1_nxt;
    logic [15:0] d1_r, d1_nxt;
    logic [15:0] dq_out_r, dq_out_nxt;
    logic [1:0] dq_oe_r, dq_oe_nxt;

    logic [2:0] cmd;
    logic take;
    logic mem_we, mem_re, mem_bank;
    logic [COL_W-1:0] mem_col, m;
    logic [15:0] mem_rdata;
    logic [1:0] lane_mask;
    logic mode_wr;
    logic [`SDC_OP_W-1:0] mode_wval;

    assign cmd = {pins.ras_n, pins.cas_n, pins.we_n};
    assign take = pins.cke && !pins.cs_n;
    assign lane_mask = {pins.high_byte_mask, pins.low_byte_mask};

    // one array of both banks; bank bit is the top address bit
    sdc_mem #(
        .AW(`SDC_MEM_AW),
        .DW(`SDC_DW)
    ) u_mem (
        .clk_sys(clk_sys),
        .we(mem_we),
        .re(mem_re),
        .be(~lane_mask),
        .addr({mem_bank, row_r[mem_bank], mem_col}),
        .wdata(dq_in),
        .rdata_r(mem_rdata)
    );

    always_comb
    begin
        state_nxt = state_r;
        bank_nxt = bank_r;
        base_nxt = base_r;
        idx_nxt = idx_r;
        mask_nxt = mask_r;
        left_nxt = left_r;
        ap_nxt = ap_r;
        il_nxt = il_r;
        full_nxt = full_r;
        active_nxt = active_r;
        row_nxt = row_r;
        mode_nxt = mode_wr ? mode_wval : mode_r;
        refcnt_nxt = refcnt_r;
        rv0_nxt = rv0_r;
        rv1_nxt = rv1_r;
        m0_nxt = m0_r;
        m1_nxt = m1_r;
        d1_nxt = d1_r;
        dq_out_nxt = dq_out_r;
        dq_oe_nxt = dq_oe_r;
        mem_we = 1'b0;
        mem_re = 1'b0;
        mem_bank = bank_r;
        mem_col = base_r;
        m = `SDC_MASK_1;
        // an edge with cke low leaves every pin-facing state untouched except mode_r, which a register-bus write still sets
        if (pins.cke)
        begin
            if (take && (cmd == `SDC_CMD_RD || cmd == `SDC_CMD_WR))
            begin
                // a new column command overrides any burst still running
                mem_col = pins.addr[COL_W-1:0];
                mem_bank = pins.bank_select_input;
                if (cmd == `SDC_CMD_WR && mode_r[`SDC_MR_WBS_BIT])
                    m = `SDC_MASK_1;
                else
                    m = bl_mask(mode_r[`SDC_MR_BL_MSB:`SDC_MR_BL_LSB]);
                mem_we = (cmd == `SDC_CMD_WR);
                mem_re = (cmd == `SDC_CMD_RD);
                bank_nxt = pins.bank_select_input;
                base_nxt = pins.addr[COL_W-1:0];
                idx_nxt = COL_W'(1);
                mask_nxt = m;
                left_nxt = {1'b0, m};
                ap_nxt = pins.addr[`SDC_PSCOPE_BIT];
                il_nxt = mode_r[`SDC_MR_BT_BIT];
                full_nxt = (m == `SDC_MASK_FULL);
                if (m == `SDC_MASK_1)
                begin
                    state_nxt = st_idle;
                    if (pins.addr[`SDC_PSCOPE_BIT])
                        active_nxt[pins.bank_select_input] = 1'b0;
                end
                else
                    state_nxt = (cmd == `SDC_CMD_WR) ? st_write : st_read;
            end
            else if (take && (cmd == `SDC_CMD_BST || cmd == `SDC_CMD_PRE))
                state_nxt = st_idle;
            else if (state_r != st_idle)
            begin
                mem_col = burst_col(base_r, idx_r, mask_r, il_r);
                mem_we = (state_r == st_write);
                mem_re = (state_r == st_read);
                idx_nxt = idx_r + COL_W'(1);
                // page bursts wrap until stopped, so they never count down
                if (!full_r)
                begin
                    left_nxt = left_r - 9'h001;
                    if (left_r == 9'h001)
                    begin
                        state_nxt = st_idle;
                        if (ap_r)
                            active_nxt[bank_r] = 1'b0;
                    end
                end
            end
            if (take && cmd == `SDC_CMD_ACT)
            begin
                active_nxt[pins.bank_select_input] = 1'b1;
                row_nxt[pins.bank_select_input] = pins.addr[ROW_W-1:0];
            end
            if (take && cmd == `SDC_CMD_PRE)
            begin
                if (pins.addr[`SDC_PSCOPE_BIT])
                    active_nxt = 2'h0;
                else
                    active_nxt[pins.bank_select_input] = 1'b0;
            end
            if (take && cmd == `SDC_CMD_MRS)
                mode_nxt = {pins.bank_select_input, pins.addr};
            if (take && cmd == `SDC_CMD_REF)
                refcnt_nxt = refcnt_r + 16'h0001;
            // read pipe: lane mask travels with the address that it covers
            rv0_nxt = mem_re;
            m0_nxt = lane_mask;
            rv1_nxt = rv0_r;
            m1_nxt = m0_r;
            d1_nxt = mem_rdata;
            if (mode_r[`SDC_MR_CL_MSB:`SDC_MR_CL_LSB] == `SDC_CL_3)
            begin
                dq_out_nxt = d1_r;
                dq_oe_nxt = rv1_r ? ~m1_r : 2'h0;
            end
            else
            begin
                dq_out_nxt = mem_rdata;
                dq_oe_nxt = rv0_r ? ~m0_r : 2'h0;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_r <= st_idle;
            bank_r <= 1'b0;
            base_r <= '0;
            idx_r <= '0;
            mask_r <= '0;
            left_r <= '0;
            ap_r <= 1'b0;
            il_r <= 1'b0;
            full_r <= 1'b0;
            active_r <= 2'h0;
            row_r <= '0;
            mode_r <= `SDC_MR_RESET;
            refcnt_r <= 16'h0000;
            rv0_r <= 1'b0;
            rv1_r <= 1'b0;
            m0_r <= 2'h0;
            m1_r <= 2'h0;
            d1_r <= 16'h0000;
            dq_out_r <= 16'h0000;
            dq_oe_r <= 2'h0;
        end
        else
        begin
            state_r <= state_nxt;
            bank_r <= bank_nxt;
            base_r <= base_nxt;
            idx_r <= idx_nxt;
            mask_r <= mask_nxt;
            left_r <= left_nxt;
            ap_r <= ap_nxt;
            il_r <= il_nxt;
            full_r <= full_nxt;
            active_r <= active_nxt;
            row_r <= row_nxt;
            mode_r <= mode_nxt;
            refcnt_r <= refcnt_nxt;
            rv0_r <= rv0_nxt;
            rv1_r <= rv1_nxt;
            m0_r <= m0_nxt;
            m1_r <= m1_nxt;
            d1_r <= d1_nxt;
            dq_out_r <= dq_out_nxt;
            dq_oe_r <= dq_oe_nxt;
        end
    end

    assign dq_out = dq_out_r;
    assign dq_oe = dq_oe_r;

    // register slave
    sdc_axi_rsp_s rsp_r, rsp_nxt;
    logic aw_got_r, aw_got_nxt;
    logic w_got_r, w_got_nxt;
    logic [31:0] aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic [31:0] wa, ra;

    always_comb
    begin
        rsp_nxt = rsp_r;
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        mode_wr = 1'b0;
        mode_wval = mode_r;
        wa = 32'h0000_0000;
        ra = {axi_req.araddr[31:2], 2'h0};
        if (rsp_r.bvalid && axi_req.bready)
            rsp_nxt.bvalid = 1'b0;
        if (axi_req.awvalid && rsp_r.awready)
        begin
            aw_got_nxt = 1'b1;
            aw_addr_nxt = axi_req.awaddr;
        end
        if (axi_req.wvalid && rsp_r.wready)
        begin
            w_got_nxt = 1'b1;
            w_data_nxt = axi_req.wdata;
            w_strb_nxt = axi_req.wstrb;
        end
        if (aw_got_nxt && w_got_nxt && !rsp_r.bvalid)
        begin
            wa = {aw_addr_nxt[31:2], 2'h0};
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            rsp_nxt.bvalid = 1'b1;
            rsp_nxt.bresp = `SDC_RESP_OKAY;
            if (wa == `SDC_OFS_MODE)
            begin
                // a mode set on the pins in the same cycle takes precedence
                mode_wr = 1'b1;
                if (w_strb_nxt[0])
                    mode_wval[7:0] = w_data_nxt[7:0];
                if (w_strb_nxt[1])
                    mode_wval[`SDC_OP_W-1:8] = w_data_nxt[`SDC_OP_W-1:8];
            end
            else
                rsp_nxt.bresp = `SDC_RESP_SLVERR;
        end
        if (rsp_r.rvalid && axi_req.rready)
            rsp_nxt.rvalid = 1'b0;
        if (axi_req.arvalid && rsp_r.arready)
        begin
            rsp_nxt.rvalid = 1'b1;
            rsp_nxt.rresp = `SDC_RESP_OKAY;
            if (ra == `SDC_OFS_MODE)
                rsp_nxt.rdata = {20'h00000, mode_r};
            else if (ra == `SDC_OFS_STATUS)
                rsp_nxt.rdata = {refcnt_r, 12'h000, state_r == st_write,
                                 state_r == st_read, active_r};
            else if (ra == `SDC_OFS_ROWS)
                rsp_nxt.rdata = {5'h00, row_r[1], 5'h00, row_r[0]};
            else
            begin
                rsp_nxt.rdata = 32'h0000_0000;
                rsp_nxt.rresp = `SDC_RESP_SLVERR;
            end
        end
        rsp_nxt.awready = !aw_got_nxt && !rsp_nxt.bvalid;
        rsp_nxt.wready = !w_got_nxt && !rsp_nxt.bvalid;
        rsp_nxt.arready = !rsp_nxt.rvalid;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rsp_r <= '0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 32'h0000_0000;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end
        else
        begin
            rsp_r <= rsp_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
        end
    end

    assign axi_rsp = rsp_r;
endmodule : sdc_top

// >>> test/sdc_ctl_model.sv
// Purpose: stand-in for the memory controller on the command pins
// Assumes: the bench orders the commands, the model records bank and refresh state
// Notes: every pin changes right after a rising edge
`timescale 1ns/1ps
`include "sdc_cfg.svh"
module sdc_ctl_model
(
    input wire logic clk_sys,
    output sdc_pkg::sdc_pins_s pins,
    output logic [15:0] dq_in
);
    import sdc_pkg::*;
    logic [1:0] open_r = 2'h0;
    int unsigned refresh_count = 0;
    initial
    begin
        pins = '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
        dq_in = 16'h5a5a;
    end
    task issue(input logic [2:0] cmd, input logic bs, input logic [10:0] addr,
        input logic [1:0] msk, input logic [15:0] data, input logic sel, input logic ce);
        @(posedge clk_sys);
        pins <= '{cke: ce, cs_n: !sel, ras_n: cmd[2], cas_n: cmd[1], we_n: cmd[0],
            bank_select_input: bs, addr: addr, high_byte_mask: msk[1], low_byte_mask: msk[0]};
        // idle beats get fresh random data so a stale word never passes for a match
        dq_in <= data;
        if (sel && ce)
        begin
            if (cmd == `SDC_CMD_ACT) open_r[bs] <= 1'b1;
            if (cmd == `SDC_CMD_PRE) open_r <= addr[10] ? 2'h0 : open_r & ~(2'h1 << bs);
            if (cmd == `SDC_CMD_REF) refresh_count <= refresh_count + 1;
            // auto-precharge closes the bank at once, on the column command itself
            if ((cmd == `SDC_CMD_RD || cmd == `SDC_CMD_WR) && addr[10]) open_r[bs] <= 1'b0;
        end
    endtask : issue
endmodule : sdc_ctl_model

// >>> test/sdc_top_properties.sv
// Purpose: port-level assertions of the dram command port
// Assumes: sees only the ports of sdc_top
// Notes: read lanes may not rise without a read two or three edges before
`timescale 1ns/1ps
`include "sdc_cfg.svh"
module sdc_top_properties
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire sdc_pkg::sdc_pins_s pins,
    input wire logic [15:0] dq_in,
    input wire logic [15:0] dq_out,
    input wire logic [1:0] dq_oe,
    input wire sdc_pkg::sdc_axi_req_s axi_req,
    input wire sdc_pkg::sdc_axi_rsp_s axi_rsp
);
    import sdc_pkg::*;
    logic rd_cmd;
    logic [1:0] lane_en;
    assign rd_cmd = pins.cke && !pins.cs_n
        && {pins.ras_n, pins.cas_n, pins.we_n} == `SDC_CMD_RD;
    assign lane_en = ~{pins.high_byte_mask, pins.low_byte_mask};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_ar_take;
        axi_req.arvalid && axi_rsp.arready;
    endsequence
    sequence s_w_take;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    a_reset_ready: assert property ($fell(reset) |=> axi_rsp.awready && axi_rsp.wready
        && axi_rsp.arready && !axi_rsp.bvalid && !axi_rsp.rvalid && dq_oe == 2'h0)
        else $error("bus not ready after reset");
    a_read_answer: assert property (s_ar_take |=> axi_rsp.rvalid && !axi_rsp.arready)
        else $error("read not answered in one cycle");
    a_read_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid
        && $stable(axi_rsp.rdata) && $stable(axi_rsp.rresp))
        else $error("read answer dropped early");
    a_read_done: assert property (axi_rsp.rvalid && axi_req.rready |=>
        !axi_rsp.rvalid && axi_rsp.arready)
        else $error("read answer not retired");
    a_write_answer: assert property (s_w_take |=> axi_rsp.bvalid
        && !axi_rsp.awready && !axi_rsp.wready)
        else $error("write not answered in one cycle");
    a_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=>
        axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write answer dropped early");
    a_write_done: assert property (axi_rsp.bvalid && axi_req.bready |=>
        !axi_rsp.bvalid ##1 axi_rsp.awready && axi_rsp.wready)
        else $error("write answer not retired");
    a_suspend_freeze: assert property (!pins.cke |=> $stable(dq_out) && $stable(dq_oe))
        else $error("data outputs moved with clock enable low");
    a_oe_cause: assert property ($rose(|dq_oe) |->
        ($past(rd_cmd, 2) && dq_oe == $past(lane_en, 2))
        || ($past(rd_cmd, 3) && dq_oe == $past(lane_en, 3)))
        else $error("lanes enabled without a matching read");
endmodule : sdc_top_properties
bind sdc_top sdc_top_properties sdc_top_properties_i (.clk_sys(clk_sys), .reset(reset),
    .pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .axi_req(axi_req),
    .axi_rsp(axi_rsp));

// >>> test/sdc_top_bench.sv
// Purpose: self-checking bench of the dram command port
// Assumes: controller stand-in drives the pins, the bench drives the register bus
// Notes: row and column per bank drawn once so stored words survive across modes
`timescale 1ns/1ps
`include "sdc_cfg.svh"
module sdc_top_bench;
    import sdc_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    sdc_pins_s pins;
    logic [15:0] dq_in, dq_out, d, e;
    logic [1:0] dq_oe, m;
    sdc_axi_req_s axi_req = '0;
    sdc_axi_rsp_s axi_rsp;
    int n_errors = 0;
    int tests_run = 0;
    int bl, k;
    logic [15:0] refv [2][256];
    bit known [2][256];
    logic [10:0] row [2];
    logic [7:0] col [2];
    logic [7:0] a;
    logic [11:0] op;
    logic [31:0] rd;
    logic bnk;
    localparam logic [2:0] NOP = 3'h7;
    localparam logic [2:0] BLC [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h2, 3'h3};
    localparam bit IL [6] = '{0, 0, 1, 0, 1, 1};
    localparam int CL [6] = '{2, 3, 2, 3, 3, 2};
    localparam bit WBS [6] = '{0, 0, 0, 0, 1, 0};
    always #2.5 clk_sys = ~clk_sys;
    sdc_top sdc_top_i (.clk_sys(clk_sys), .reset(reset), .pins(pins), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .axi_req(axi_req), .axi_rsp(axi_rsp));
    sdc_ctl_model sdc_ctl_model_i (.clk_sys(clk_sys), .pins(pins), .dq_in(dq_in));
    function automatic logic [7:0] col_at(logic [7:0] b, int j, int n, bit il);
        logic [7:0] w;
        w = 8'(n - 1);
        return il ? (b ^ 8'(j)) : ((b & ~w) | ((b + 8'(j)) & w));
    endfunction : col_at
    function automatic logic [15:0] lanes(logic [1:0] mk);
        return {{8{~mk[1]}}, {8{~mk[0]}}};
    endfunction : lanes
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task close_out;
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task cyc(input logic [2:0] c, input logic bs, input logic [10:0] ad, input logic [1:0] mk,
        input logic [15:0] dd, input logic sel = 1'b1, input logic ce = 1'b1);
        sdc_ctl_model_i.issue(c, bs, ad, mk, dd, sel, ce);
        #1;
    endtask : cyc
    task idle(input int n);
        repeat (n) cyc(NOP, 1'b0, 11'h0, 2'h0, 16'($urandom));
    endtask : idle
    task automatic axi_wr(input logic [31:0] ad, input logic [31:0] dd, input logic [1:0] er);
        @(posedge clk_sys);
        axi_req.awaddr <= ad;
        axi_req.wdata <= dd;
        axi_req.wstrb <= 4'hf;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end
        while (axi_rsp.bvalid !== 1'b1);
        axi_req.bready <= 1'b0;
        check("bresp", {30'h0, axi_rsp.bresp}, {30'h0, er});
    endtask : axi_wr
    task automatic axi_rd(input logic [31:0] ad, input logic [1:0] er);
        @(posedge clk_sys);
        axi_req.araddr <= ad;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end
        while (axi_rsp.rvalid !== 1'b1);
        axi_req.rready <= 1'b0;
        rd = axi_rsp.rdata;
        check("rresp", {30'h0, axi_rsp.rresp}, {30'h0, er});
    endtask : axi_rd
    task st_is(input logic [3:0] exp);
        idle(1);
        axi_rd(`SDC_OFS_STATUS, `SDC_RESP_OKAY);
        check("status", {28'h0, rd[3:0]}, {28'h0, exp});
        check("open banks", {30'h0, rd[1:0]}, {30'h0, sdc_ctl_model_i.open_r});
    endtask : st_is
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        close_out();
    end
    initial
    begin
        rd = $urandom(32'h2454);
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        for (int b = 0; b < 2; b++)
        begin
            row[b] = 11'($urandom);
            col[b] = 8'($urandom);
        end
        axi_rd(`SDC_OFS_MODE, `SDC_RESP_OKAY);
        check("mode reset", rd, 32'(`SDC_MR_RESET));
        axi_rd(32'h0000_000c, `SDC_RESP_SLVERR);
        check("unmapped", rd, 32'h0);
        axi_wr(`SDC_OFS_STATUS, 32'hffff_ffff, `SDC_RESP_SLVERR);
        cyc(`SDC_CMD_REF, 1'b0, 11'h0, 2'h0, 16'h0);
        idle(1);
        axi_rd(`SDC_OFS_STATUS, `SDC_RESP_OKAY);
        check("refresh count", rd, {16'(sdc_ctl_model_i.refresh_count), 16'h0});
        for (int c = 0; c < 6; c++)
        begin
            bnk = 1'(c % 2);
            bl = 1 << BLC[c];
            op = {1'($urandom), 1'b0, WBS[c], 2'h0, (CL[c] == 3) ? 3'h3 : 3'h2, IL[c], BLC[c]};
            cyc(`SDC_CMD_MRS, op[11], op[10:0], 2'h0, 16'h0);
            idle(1);
            axi_rd(`SDC_OFS_MODE, `SDC_RESP_OKAY);
            check("opcode", rd, {20'h0, op});
            cyc(`SDC_CMD_ACT, bnk, row[bnk], 2'h0, 16'h0);
            idle(1);
            axi_rd(`SDC_OFS_ROWS, `SDC_RESP_OKAY);
            check("row", {21'h0, bnk ? rd[26:16] : rd[10:0]}, {21'h0, row[bnk]});
            // first pass unmasked so every byte is known, second pass masks at random
            for (int p = 0; p < 2; p++)
                for (int j = 0; j < bl; j++)
                begin
                    m = p ? 2'($urandom) : 2'h0;
                    d = 16'($urandom);
                    cyc(j ? NOP : `SDC_CMD_WR, bnk, {3'h0, col[bnk]}, m, d);
                    a = col_at(col[bnk], j, bl, IL[c]);
                    if (j == 0 || !WBS[c])
                    begin
                        refv[bnk][a] = (refv[bnk][a] & ~lanes(m)) | (d & lanes(m));
                        known[bnk][a] = 1'b1;
                    end
                end
            m = 2'($urandom);
            cyc(`SDC_CMD_RD, bnk, {3'h4, col[bnk]}, m, 16'($urandom));
            for (int i = 1; i <= CL[c] + bl; i++)
            begin
                // masks act per beat, so the read mask is held for the whole burst
                cyc(NOP, 1'b0, 11'h0, m, 16'($urandom));
                k = i - CL[c];
                a = col_at(col[bnk], k, bl, IL[c]);
                e = refv[bnk][a] & lanes(m);
                if (k >= 0 && k < bl)
                begin
                    check("lanes", {30'h0, dq_oe}, {30'h0, ~m});
                    if (known[bnk][a]) check("data", {16'h0, dq_out & lanes(m)}, {16'h0, e});
                end
                else if (k == bl) check("lanes off", {30'h0, dq_oe}, 32'h0);
            end
            st_is(4'h0);
        end
        cyc(`SDC_CMD_ACT, 1'b0, row[0], 2'h0, 16'h0);
        cyc(`SDC_CMD_ACT, 1'b1, row[1], 2'h0, 16'h0);
        st_is(4'h3);
        cyc(`SDC_CMD_PRE, 1'b0, 11'h000, 2'h0, 16'h0);
        st_is(4'h2);
        cyc(`SDC_CMD_ACT, 1'b0, row[0], 2'h0, 16'h0, 1'b0);
        cyc(`SDC_CMD_ACT, 1'b0, row[0], 2'h0, 16'h0, 1'b1, 1'b0);
        st_is(4'h2);
        cyc(`SDC_CMD_PRE, 1'b0, 11'h400, 2'h0, 16'h0);
        st_is(4'h0);
        axi_wr(`SDC_OFS_MODE, 32'h0000_0027, `SDC_RESP_OKAY);
        axi_rd(`SDC_OFS_MODE, `SDC_RESP_OKAY);
        check("mode write", rd, 32'h0000_0027);
        for (int t = 0; t < 2; t++)
        begin
            cyc(`SDC_CMD_ACT, 1'b1, row[1], 2'h0, 16'h0);
            cyc(`SDC_CMD_RD, 1'b1, {3'h0, col[1]}, 2'h0, 16'($urandom));
            st_is(4'h6);
            cyc(t ? `SDC_CMD_PRE : `SDC_CMD_BST, 1'b1, 11'h0, 2'h0, 16'h0);
            idle(3);
            check("stopped lanes", {30'h0, dq_oe}, 32'h0);
            st_is(t ? 4'h0 : 4'h2);
            if (t == 0) cyc(`SDC_CMD_PRE, 1'b1, 11'h0, 2'h0, 16'h0);
        end
        close_out();
    end
endmodule : sdc_top_bench
